// ---- hdl/dpi_regs.vh ----
// Purpose: shared constants of the parallel sample input port
// Assumes: included by bare name from the delay line and top design files; the synchroniser does not include it
// Notes:   addresses are those of the configuration registers whose bits arrive as ports
`ifndef DPI_REGS_VH
`define DPI_REGS_VH

// sample word width and mid-scale code (two's complement zero)
`define DPI_WORD_W          16
`define DPI_MIDSCALE        16'h0000

// latencies in sample-clock cycles
`define DPI_LAT_PORT_A      10
`define DPI_LAT_PORT_B      11
`define DPI_LAT_SINGLE_INT  7

// sample clock to forwarded clock ratios
`define DPI_RATIO_DUAL      4'h4
`define DPI_RATIO_SINGLE    4'h2

// fixed part of the in-phase capture delay, in system clock cycles
`define DPI_CAPT_BASE       4'h2

// configuration register addresses mirrored by port groups
`define DPI_ADDR_OCLK_CFG   8'h02
`define DPI_ADDR_TEST_CFG0  8'h18
`define DPI_ADDR_TEST_CFG1  8'h19

// field positions inside the mirrored registers
`define DPI_TEST_EN_BIT     0
`define DPI_TEST_TIMING_BIT 0

`endif

// ---- hdl/dpi_sync.v ----
// Purpose: two-flop synchroniser for a group of asynchronous levels
// Assumes: each bit is an independent level; reset is held long enough to flush the chain
// Notes:   the first stage feeds only the second stage; no reset, so the chain always shows the pin
`timescale 1ns/1ps
module dpi_sync #(
  parameter WIDTH = 1
) (
  input  wire             clk_sys_in,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out
);

  reg [WIDTH-1:0] meta_ff;  // first stage, may go metastable
  reg [WIDTH-1:0] sync_ff;  // second stage, safe to use

  // plain two-stage chain; it follows the pins through reset, because a zeroed chain
  // would fake a clock edge and a power-down request just after reset is released
  always @(posedge clk_sys_in)
  begin
    meta_ff <= async_in;
    sync_ff <= meta_ff;
  end

  assign sync_out = sync_ff;

endmodule

// ---- hdl/dpi_delay.v ----
// Purpose: fixed sample-clock delay line for converter words
// Assumes: shift_in pulses once per sample-clock rising edge
// Notes:   a word loaded on tick t appears on word_out at tick t+DEPTH-1
`timescale 1ns/1ps
`include "dpi_regs.vh"
module dpi_delay #(
  parameter WIDTH = 16,
  parameter DEPTH = 10
) (
  input  wire             clk_sys_in,
  input  wire             rst_n_in,
  input  wire             clear_in,
  input  wire             shift_in,
  input  wire [WIDTH-1:0] word_in,
  output reg  [WIDTH-1:0] word_out
);

  reg [WIDTH-1:0] stage_mem [0:DEPTH-2];  // stages before the output flop
  integer         i;

  // shift on each tick; clear flushes to mid-scale so power-down leaves no stale code
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in || clear_in)
    begin
      for (i = 0; i < DEPTH-1; i = i + 1)
        stage_mem[i] <= `DPI_MIDSCALE;
      word_out <= `DPI_MIDSCALE;
    end
    else if (shift_in)
    begin
      stage_mem[0] <= word_in;
      for (i = 1; i < DEPTH-1; i = i + 1)
        stage_mem[i] <= stage_mem[i-1];
      word_out <= stage_mem[DEPTH-2];
    end
  end

endmodule

// ---- hdl/dpi_top.v ----
// Purpose: parallel sample input port: capture, interleave, retime, delay, clock out
// Assumes: clk_sys_in is much faster than both the forwarded and the sample clock
// Notes:   both incoming clocks are sampled, their edges found after two flops
//
// How it works
// - dual mode uses port A; single ignores it
// - single mode takes every sample from port B
// - port B word follows port A by one cycle
// - words are two's complement, passed unchanged
// - forwarded clock is quarter or half sample clock
// - host clock output divides sample clock by four/two
// - drive current and termination follow select bits
// - phase select and three-bit capture timing adjust
// - latency counted in sample-clock cycles from capture
// - all-zero code is mid-scale output
// - power-down while power-down input is low
// - test output pair driven by two control bytes
// - dual latency ten for A, eleven for B
// - single latency 7.5 from following falling edge
// - four capture groups, four-to-one mux, A first
`timescale 1ns/1ps
`include "dpi_regs.vh"
module dpi_top #(
  parameter WORD_W = `DPI_WORD_W
) (
  input  wire              clk_sys_in,
  input  wire              rst_n_in,
  input  wire              converter_sample_clock_in,
  input  wire              forwarded_input_clock_in,
  input  wire [WORD_W-1:0] port_a_sample_lanes_in,
  input  wire [WORD_W-1:0] port_b_sample_lanes_in,
  input  wire              power_down_n_in,
  input  wire              dual_port_mode_in,
  input  wire              out_clock_rate_sel_in,
  input  wire              out_clock_current_sel_in,
  input  wire              out_clock_term_enable_in,
  input  wire              in_clock_phase_sel_in,
  input  wire [2:0]        in_capture_timing_adjust_in,
  input  wire [7:0]        test_ctrl0_in,
  input  wire [7:0]        test_ctrl1_in,
  output reg  [WORD_W-1:0] converter_current_output_out,
  output reg               converter_update_out,
  output reg               host_clock_output_out,
  output reg               out_clock_drive_50ohm_out,
  output reg               out_clock_term_on_out,
  output reg               test_output_pair_out,
  output reg               test_output_en_out,
  output reg               clock_ratio_error_out,
  output reg               powered_down_out
);

  // synchronised pins
  wire [2:0]          clk_sync;     // sample clock, forwarded clock, power-down
  wire [2*WORD_W-1:0] lane_sync;    // port B high half, port A low half
  wire                sclk_s;       // sampled converter clock level
  wire                fclk_s;       // sampled forwarded clock level
  wire                pd_n_s;       // sampled power-down level
  wire [WORD_W-1:0]   lane_a_s;     // sampled port A lanes
  wire [WORD_W-1:0]   lane_b_s;     // sampled port B lanes

  // edge detection history
  reg                 sclk_d_ff;    // previous sample clock level
  reg                 fclk_d_ff;    // previous forwarded clock level
  wire                s_rise;       // sample clock rising edge
  wire                s_fall;       // sample clock falling edge
  wire                f_rise;       // forwarded clock rising edge
  wire                f_edge;       // either forwarded clock edge

  // capture machinery
  reg  [3:0]          cap_cnt_ff;   // delay left before capture
  reg                 cap_wait_ff;  // a capture is scheduled
  reg                 cap_rise_ff;  // scheduled capture belongs to a rising edge
  reg  [WORD_W-1:0]   a_rise_ff;    // group 1: port A at rising edge
  reg  [WORD_W-1:0]   b_rise_ff;    // group 2: port B at rising edge
  reg  [WORD_W-1:0]   a_fall_ff;    // group 3: port A at falling edge
  reg  [WORD_W-1:0]   b_fall_ff;    // group 4: port B at falling edge
  reg                 cap_done_ff;  // one-cycle pulse: a group pair was loaded
  reg                 cap_edge_ff;  // edge of the last loaded pair, 1 = rising
  reg                 cap_tog_ff;   // toggles per capture, seen on the test pair

  // interleave state
  reg                 pend_a_ff;    // port A word waits for a sample edge
  reg                 pend_b_ff;    // port B word waits for a sample edge
  reg                 armed_ff;     // single mode: falling edge seen after capture
  reg                 arm_edge_ff;  // capture edge of the armed word, 1 = rising
  reg  [WORD_W-1:0]   nxt_word;     // word entering the delay lines this tick
  reg                 take_a;       // this tick consumes the port A word
  reg                 take_b;       // this tick consumes the port B word

  // delay line outputs
  wire [WORD_W-1:0]   dual_word;    // dual path output
  wire [WORD_W-1:0]   single_word;  // single path output

  // host clock divider and ratio check
  reg  [1:0]          div_cnt_ff;   // sample edges since last output toggle
  reg  [3:0]          ratio_cnt_ff; // sample edges since last forwarded rise
  reg                 ratio_seen_ff;// a forwarded rise has been counted from

  // capture delay for the in-phase case: fixed margin plus adjust step
  function [3:0] capt_delay;
    input [2:0] adj;
    begin
      capt_delay = `DPI_CAPT_BASE + {1'b0, adj};
    end
  endfunction

  // group selection of the 4:1 mux: pick the rising or falling pair
  function [WORD_W-1:0] pick_group;
    input             rise;
    input [WORD_W-1:0] from_rise;
    input [WORD_W-1:0] from_fall;
    begin
      pick_group = rise ? from_rise : from_fall;
    end
  endfunction

  // one synchroniser for the clocks and power-down, one for the lanes
  dpi_sync #(
    .WIDTH (3)
  ) u_sync_ctl (
    .clk_sys_in (clk_sys_in),
    .async_in   ({converter_sample_clock_in, forwarded_input_clock_in, power_down_n_in}),
    .sync_out   (clk_sync)
  );

  dpi_sync #(
    .WIDTH (2*WORD_W)
  ) u_sync_lane (
    .clk_sys_in (clk_sys_in),
    .async_in   ({port_b_sample_lanes_in, port_a_sample_lanes_in}),
    .sync_out   (lane_sync)
  );

  assign sclk_s   = clk_sync[2];
  assign fclk_s   = clk_sync[1];
  assign pd_n_s   = clk_sync[0];
  assign lane_a_s = lane_sync[WORD_W-1:0];
  assign lane_b_s = lane_sync[2*WORD_W-1:WORD_W];

  // edges are found from the second stage only; the history follows the pin
  // through reset, so the first edge seen after reset is a real one
  always @(posedge clk_sys_in)
  begin
    sclk_d_ff <= sclk_s;
    fclk_d_ff <= fclk_s;
  end

  assign s_rise = sclk_s & ~sclk_d_ff;
  assign s_fall = ~sclk_s & sclk_d_ff;
  assign f_rise = fclk_s & ~fclk_d_ff;
  assign f_edge = fclk_s ^ fclk_d_ff;

  // capture on both forwarded clock edges into four groups
  // quadrature clock: data is centred on the edge, so take it at once;
  // in-phase clock: data changes at the edge, so wait for the eye
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !pd_n_s)
    begin
      cap_cnt_ff  <= 4'h0;
      cap_wait_ff <= 1'b0;
      cap_rise_ff <= 1'b0;
      a_rise_ff   <= `DPI_MIDSCALE;
      b_rise_ff   <= `DPI_MIDSCALE;
      a_fall_ff   <= `DPI_MIDSCALE;
      b_fall_ff   <= `DPI_MIDSCALE;
      cap_done_ff <= 1'b0;
      cap_edge_ff <= 1'b0;
      cap_tog_ff  <= 1'b0;
    end
    else
    begin
      cap_done_ff <= 1'b0;
      if (f_edge)
      begin
        // a new edge restarts the wait; lanes still hold this edge's data
        cap_wait_ff <= 1'b1;
        cap_rise_ff <= fclk_s;
        cap_cnt_ff  <= in_clock_phase_sel_in ? 4'h0 : capt_delay(in_capture_timing_adjust_in);
      end
      else if (cap_wait_ff && cap_cnt_ff != 4'h0)
        cap_cnt_ff <= cap_cnt_ff - 4'h1;
      else if (cap_wait_ff)
      begin
        // rising and falling groups for each port
        cap_wait_ff <= 1'b0;
        cap_done_ff <= 1'b1;
        cap_edge_ff <= cap_rise_ff;
        cap_tog_ff  <= ~cap_tog_ff;
        if (cap_rise_ff)
        begin
          a_rise_ff <= dual_port_mode_in ? lane_a_s : `DPI_MIDSCALE;
          b_rise_ff <= lane_b_s;
        end
        else
        begin
          a_fall_ff <= dual_port_mode_in ? lane_a_s : `DPI_MIDSCALE;
          b_fall_ff <= lane_b_s;
        end
      end
    end
  end

  // pick the word for this sample tick; idle ticks insert mid-scale
  always @*
  begin
    nxt_word = `DPI_MIDSCALE;
    take_a   = 1'b0;
    take_b   = 1'b0;
    if (dual_port_mode_in)
    begin
      // port A goes first, port B on the following tick
      if (pend_b_ff)
      begin
        nxt_word = pick_group(cap_edge_ff, b_rise_ff, b_fall_ff);
        take_b   = 1'b1;
      end
      else if (pend_a_ff)
      begin
        nxt_word = pick_group(cap_edge_ff, a_rise_ff, a_fall_ff);
        take_a   = 1'b1;
      end
    end
    else if (armed_ff)
    begin
      nxt_word = pick_group(arm_edge_ff, b_rise_ff, b_fall_ff);
      take_b   = 1'b1;
    end
  end

  // pending flags: a fresh capture wins over consumption in the same cycle
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !pd_n_s)
    begin
      pend_a_ff   <= 1'b0;
      pend_b_ff   <= 1'b0;
      armed_ff    <= 1'b0;
      arm_edge_ff <= 1'b0;
    end
    else if (dual_port_mode_in)
    begin
      armed_ff <= 1'b0;
      if (cap_done_ff)
      begin
        pend_a_ff <= 1'b1;
        pend_b_ff <= 1'b0;
      end
      else if (s_rise && take_a)
      begin
        pend_a_ff <= 1'b0;
        pend_b_ff <= 1'b1;
      end
      else if (s_rise && take_b)
        pend_b_ff <= 1'b0;
    end
    else
    begin
      // count from the falling edge that follows the capture
      // the next capture lands before the armed word is used, so it keeps its own group
      pend_a_ff <= 1'b0;
      if (s_fall && pend_b_ff)
      begin
        armed_ff    <= 1'b1;
        arm_edge_ff <= cap_edge_ff;
      end
      else if (s_rise && armed_ff)
        armed_ff <= 1'b0;
      if (cap_done_ff)
        pend_b_ff <= 1'b1;
      else if (s_fall)
        pend_b_ff <= 1'b0;
    end
  end

  // single-mode capture marks port B pending through the same flag
  // (the dual branch never sees it set here because the mode gates it)

  // dual path: A loaded on the first tick lands ten ticks later
  // B loaded one tick after it lands eleven ticks after the first tick
  dpi_delay #(
    .WIDTH (WORD_W),
    .DEPTH (`DPI_LAT_PORT_A)
  ) u_delay_dual (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .clear_in   (!pd_n_s),
    .shift_in   (s_rise),
    .word_in    (nxt_word),
    .word_out   (dual_word)
  );

  // single path: loaded half a cycle after the falling edge, seven more
  dpi_delay #(
    .WIDTH (WORD_W),
    .DEPTH (`DPI_LAT_SINGLE_INT)
  ) u_delay_single (
    .clk_sys_in (clk_sys_in),
    .rst_n_in   (rst_n_in),
    .clear_in   (!pd_n_s),
    .shift_in   (s_rise),
    .word_in    (nxt_word),
    .word_out   (single_word)
  );

  // converter update on each sample rising edge; codes pass untouched
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !pd_n_s)
    begin
      converter_current_output_out <= `DPI_MIDSCALE;
      converter_update_out         <= 1'b0;
    end
    else
    begin
      converter_update_out <= s_rise;
      if (s_rise)
        converter_current_output_out <= dual_port_mode_in ? dual_word : single_word;
    end
  end

  // host clock: toggle every two sample edges for /4, every edge for /2
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !pd_n_s)
    begin
      div_cnt_ff            <= 2'h0;
      host_clock_output_out <= 1'b0;
    end
    else if (s_rise)
    begin
      if (!out_clock_rate_sel_in || div_cnt_ff == 2'h1)
      begin
        div_cnt_ff            <= 2'h0;
        host_clock_output_out <= ~host_clock_output_out;
      end
      else
        div_cnt_ff <= div_cnt_ff + 2'h1;
    end
  end

  // ratio check: sample edges per forwarded period must match the mode
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in || !pd_n_s)
    begin
      ratio_cnt_ff          <= 4'h0;
      ratio_seen_ff         <= 1'b0;
      clock_ratio_error_out <= 1'b0;
    end
    else
    begin
      if (f_rise)
      begin
        ratio_seen_ff <= 1'b1;
        ratio_cnt_ff  <= {3'h0, s_rise};
        if (ratio_seen_ff)
          clock_ratio_error_out <= ratio_cnt_ff !=
            (dual_port_mode_in ? `DPI_RATIO_DUAL : `DPI_RATIO_SINGLE);
      end
      else if (s_rise && ratio_cnt_ff != 4'hF)
        ratio_cnt_ff <= ratio_cnt_ff + 4'h1;
    end
  end

  // analog controls, power state and test pair
  always @(posedge clk_sys_in)
  begin
    if (!rst_n_in)
    begin
      out_clock_drive_50ohm_out <= 1'b0;
      out_clock_term_on_out     <= 1'b0;
      test_output_pair_out      <= 1'b0;
      test_output_en_out        <= 1'b0;
      powered_down_out          <= 1'b0;
    end
    else
    begin
      out_clock_drive_50ohm_out <= out_clock_current_sel_in;
      out_clock_term_on_out     <= out_clock_term_enable_in;
      powered_down_out          <= ~pd_n_s;
      test_output_en_out        <= test_ctrl0_in[`DPI_TEST_EN_BIT] & pd_n_s;
      // timing mode shows each capture as a level change; otherwise held low
      test_output_pair_out      <= test_ctrl0_in[`DPI_TEST_EN_BIT] &
                                   test_ctrl1_in[`DPI_TEST_TIMING_BIT] & cap_tog_ff;
    end
  end

endmodule

// ---- tb/dpi_top_monitor.sv ----
// Purpose: port checker for the parallel sample input port
// Assumes: sample clock period is at least ten system cycles
// Notes:   sample rises are found here with a two-flop delay like the block's own
`timescale 1ns/1ps
module dpi_top_monitor #(
  parameter WORD_W = 16
) (
  input wire              clk_sys_in,
  input wire              rst_n_in,
  input wire              converter_sample_clock_in,
  input wire              power_down_n_in,
  input wire              out_clock_rate_sel_in,
  input wire              out_clock_current_sel_in,
  input wire              out_clock_term_enable_in,
  input wire [7:0]        test_ctrl0_in,
  input wire [7:0]        test_ctrl1_in,
  input wire [WORD_W-1:0] converter_current_output_out,
  input wire              converter_update_out,
  input wire              host_clock_output_out,
  input wire              out_clock_drive_50ohm_out,
  input wire              out_clock_term_on_out,
  input wire              test_output_pair_out,
  input wire              test_output_en_out,
  input wire              powered_down_out
);
  reg  [2:0] smp_ff;      // sample pin history
  reg  [2:0] rise_cnt_ff; // sample rises since the last host clock toggle
  reg  [1:0] tog_cnt_ff;  // toggles seen; the first interval is partial
  reg        hclk_ff;     // host clock one cycle back
  wire       smp_rise = smp_ff[1] & ~smp_ff[2];

  // count rises per host clock half period; a coincident rise opens the new interval
  always @(posedge clk_sys_in)
  begin
    smp_ff  <= {smp_ff[1:0], converter_sample_clock_in};
    hclk_ff <= host_clock_output_out;
    if (!rst_n_in || !power_down_n_in || powered_down_out)
    begin
      rise_cnt_ff <= 3'h0;
      tog_cnt_ff  <= 2'h0;
    end
    else if (hclk_ff != host_clock_output_out)
    begin
      rise_cnt_ff <= {2'h0, smp_rise};
      if (tog_cnt_ff != 2'h3)
        tog_cnt_ff <= tog_cnt_ff + 2'h1;
    end
    else if (smp_rise)
      rise_cnt_ff <= rise_cnt_ff + 3'h1;
  end

  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  // power-down pin held long enough to pass the synchroniser
  sequence pd_held_s;
    $stable(power_down_n_in) [*6];
  endsequence
  // quiet gap: four cycles with no code update
  sequence quiet_gap_s;
    !converter_update_out [*4];
  endsequence

  drive_copy_a: assert property ($stable(out_clock_current_sel_in) [*5] |->
    out_clock_drive_50ohm_out == out_clock_current_sel_in) else $error("drive select not mirrored");
  term_copy_a: assert property ($stable(out_clock_term_enable_in) [*5] |->
    out_clock_term_on_out == out_clock_term_enable_in) else $error("termination not mirrored");
  pd_flag_a: assert property (pd_held_s |-> powered_down_out == !power_down_n_in)
    else $error("power-down flag wrong");
  pd_midscale_a: assert property (powered_down_out |-> converter_current_output_out == '0)
    else $error("code not mid-scale in power-down");
  hclk_div_a: assert property ($changed(host_clock_output_out) && tog_cnt_ff != 2'h0 |->
    rise_cnt_ff == (out_clock_rate_sel_in ? 3'h2 : 3'h1)) else $error("host clock ratio wrong");
  update_gap_a: assert property (converter_update_out |=> quiet_gap_s)
    else $error("updates closer than a sample period");
  update_cause_a: assert property (converter_update_out |->
    $past(smp_rise, 1) || $past(smp_rise, 2) || $past(smp_rise, 3)) else $error("update without sample rise");
  code_hold_a: assert property ($changed(converter_current_output_out) |->
    converter_update_out || converter_current_output_out == '0) else $error("code moved without update");
  pair_quiet_a: assert property ((!(test_ctrl0_in[0] && test_ctrl1_in[0])) [*4] |->
    $stable(test_output_pair_out)) else $error("test pair moved while off");
  test_en_a: assert property ($stable({test_ctrl0_in[0], powered_down_out}) [*4] |->
    test_output_en_out == (test_ctrl0_in[0] && !powered_down_out)) else $error("test enable wrong");
endmodule

bind dpi_top dpi_top_monitor #(.WORD_W(WORD_W)) i_mon (.*);

// ---- tb/dpi_host_model.sv ----
// Purpose: host side of the parallel sample link
// Assumes: forwarded clock and words are timed from the sample clock
// Notes:   words keep changing while stopped, so stale data never looks valid
`timescale 1ns/1ps
module dpi_host_model (
  input  wire        smp_clk_in,
  input  wire        run_in,
  input  wire        dual_in,
  input  wire        bad_ratio_in,
  input  wire        junk_a_in,
  output reg         fwd_clk_out,
  output reg  [15:0] port_a_out,
  output reg  [15:0] port_b_out
);
  reg [15:0] word_ff = 16'h0000; // running pattern, wraps through negative codes
  reg        ph_ff = 1'b0;       // sample fall phase

  initial
  begin
    fwd_clk_out = 1'b0;
    port_a_out  = 16'h0000;
    port_b_out  = 16'h0000;
  end

  // next word pair; port A grounded in single mode unless a fault is asked for
  task load_word;
  begin
    word_ff    = word_ff + 16'h1357;
    port_b_out = word_ff;
    port_a_out = dual_in ? ~word_ff : (junk_a_in ? word_ff : 16'h0000);
  end
  endtask

  // forwarded edges on sample falls: every second in dual, every one in single
  always @(negedge smp_clk_in)
  begin
    ph_ff = ~ph_ff;
    if (run_in && (!(dual_in ^ bad_ratio_in) || ph_ff))
      fwd_clk_out = ~fwd_clk_out;
    if (dual_in && !ph_ff)
      load_word;
  end

  // single mode changes data half way between edges
  always @(posedge smp_clk_in)
    if (!dual_in)
      load_word;
endmodule

// ---- tb/dpi_top_tb.sv ----
// Purpose: stream tests of the parallel sample input port
// Assumes: the host model clocks its data from the sample clock
// Notes:   each forwarded edge queues its words with the sample rise they are due on
`timescale 1ns/1ps
module dpi_top_tb;
  reg         clk_sys_in = 1'b0;
  reg         rst_n_in = 1'b0;
  reg         converter_sample_clock_in = 1'b0;
  wire        forwarded_input_clock_in;
  wire [15:0] port_a_sample_lanes_in;
  wire [15:0] port_b_sample_lanes_in;
  reg         power_down_n_in = 1'b1;
  reg         dual_port_mode_in = 1'b1;
  reg         out_clock_rate_sel_in = 1'b1;
  reg         out_clock_current_sel_in = 1'b0;
  reg         out_clock_term_enable_in = 1'b0;
  reg         in_clock_phase_sel_in = 1'b1;
  reg  [2:0]  in_capture_timing_adjust_in = 3'h0;
  reg  [7:0]  test_ctrl0_in = 8'h00;
  reg  [7:0]  test_ctrl1_in = 8'h00;
  wire [15:0] converter_current_output_out;
  wire        converter_update_out;
  wire        host_clock_output_out;
  wire        out_clock_drive_50ohm_out;
  wire        out_clock_term_on_out;
  wire        test_output_pair_out;
  wire        test_output_en_out;
  wire        clock_ratio_error_out;
  wire        powered_down_out;
  reg         run = 1'b0;        // host streams while high
  reg         bad = 1'b0;        // host breaks the clock ratio
  reg         junk = 1'b0;       // host drives port A in single mode
  reg         sb_on = 1'b0;      // scoreboard active
  integer     smp_half = 20;     // sample clock half period in ns
  integer     rise_cnt = 0;      // sample rises so far
  integer     cyc = 0;           // cycles run, for the hang limit
  integer     fails = 0;
  integer     samples_checked = 0;
  integer     exp_t[$];          // due sample rise of each queued word
  reg  [15:0] exp_v[$];          // queued word

  dpi_top i_dut (.*);

  dpi_host_model i_host (
    .smp_clk_in   (converter_sample_clock_in),
    .run_in       (run),
    .dual_in      (dual_port_mode_in),
    .bad_ratio_in (bad),
    .junk_a_in    (junk),
    .fwd_clk_out  (forwarded_input_clock_in),
    .port_a_out   (port_a_sample_lanes_in),
    .port_b_out   (port_b_sample_lanes_in)
  );

  always #2 clk_sys_in = ~clk_sys_in;

  // sample clock offset from the system clock so edges never coincide
  initial #1.3 forever #(smp_half) converter_sample_clock_in = ~converter_sample_clock_in;

  always @(posedge converter_sample_clock_in) rise_cnt = rise_cnt + 1;

  // queue words at each forwarded edge; first rise after it is rise_cnt+1
  always @(forwarded_input_clock_in)
    if (sb_on)
    begin
      if (dual_port_mode_in)
      begin
        exp_t.push_back(rise_cnt + 11);
        exp_v.push_back(port_a_sample_lanes_in);
        exp_t.push_back(rise_cnt + 12);
        exp_v.push_back(port_b_sample_lanes_in);
      end
      else
      begin
        exp_t.push_back(rise_cnt + 9);
        exp_v.push_back(port_b_sample_lanes_in);
      end
    end

  // every update is either the word due now or an idle mid-scale code
  always @(posedge clk_sys_in)
  begin
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      fails = fails + 1;
      final_report;
    end
    if (sb_on && converter_update_out === 1'b1)
    begin
      if (exp_t.size() != 0 && exp_t[0] == rise_cnt)
      begin
        check_word(converter_current_output_out, exp_v[0]);
        exp_t.pop_front();
        exp_v.pop_front();
      end
      else
        check_word(converter_current_output_out, 16'h0000);
    end
  end

  task step(input integer n);
  begin
    repeat (n) @(posedge clk_sys_in);
    #1;
  end
  endtask

  task check_word(input [15:0] got, input [15:0] exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task check_flag(input got, input exp);
  begin
    samples_checked = samples_checked + 1;
    if (got !== exp)
    begin
      fails = fails + 1;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  task final_report;
  begin
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  end
  endtask

  initial
  begin
    step(3);
    rst_n_in = 1'b1;
    step(5);
    // dual mode, quadrature capture, host clock at a quarter rate
    out_clock_current_sel_in = 1'b1;
    out_clock_term_enable_in = 1'b1;
    sb_on = 1'b1;
    run = 1'b1;
    step(1000);
    check_flag(out_clock_drive_50ohm_out, 1'b1);
    check_flag(out_clock_term_on_out, 1'b1);
    check_flag(clock_ratio_error_out, 1'b0);
    run = 1'b0;
    step(200);
    check_flag(exp_t.size() == 0, 1'b1);
    $display("test dual_stream done");
    // power-down, then single mode with in-phase capture and junk on port A
    power_down_n_in = 1'b0;
    test_ctrl0_in = 8'h01;
    test_ctrl1_in = 8'h01;
    step(10);
    check_flag(powered_down_out, 1'b1);
    check_word(converter_current_output_out, 16'h0000);
    check_flag(test_output_en_out, 1'b0);
    dual_port_mode_in = 1'b0;
    smp_half = 40;
    in_clock_phase_sel_in = 1'b0;
    in_capture_timing_adjust_in = 3'h1;
    out_clock_rate_sel_in = 1'b0;
    out_clock_current_sel_in = 1'b0;
    junk = 1'b1;
    step(10);
    power_down_n_in = 1'b1;
    step(20);
    check_flag(powered_down_out, 1'b0);
    check_flag(test_output_en_out, 1'b1);
    run = 1'b1;
    step(1000);
    check_flag(out_clock_drive_50ohm_out, 1'b0);
    check_flag(clock_ratio_error_out, 1'b0);
    run = 1'b0;
    step(250);
    check_flag(exp_t.size() == 0, 1'b1);
    $display("test single_stream done");
    // forwarded clock at the dual rate while in single mode
    sb_on = 1'b0;
    bad = 1'b1;
    run = 1'b1;
    step(600);
    check_flag(clock_ratio_error_out, 1'b1);
    run = 1'b0;
    $display("test ratio_fault done");
    final_report;
  end
endmodule
